// *** rtl/pfd_arm_ctl.sv ***
// Armed state of one double-buffered register group
`timescale 1ns/1ns
module pfd_arm_ctl (
  input wire logic i_clk,
  input wire logic i_rst,
  pfd_arm_if.ctl   arm
);
  typedef enum logic {PFD_IDLE, PFD_ARMED} pfd_arm_state_t;
  typedef struct packed {
    pfd_arm_state_t state;
  } pfd_arm_st_t;

  pfd_arm_st_t s_q;
  pfd_arm_st_t s_d;

  assign arm.armed = (s_q.state == PFD_ARMED);
  assign arm.load  = (s_q.state == PFD_ARMED) && arm.update;

  always_comb begin
    s_d = s_q;
    unique case (s_q.state)
      PFD_IDLE: begin
        if (arm.arm_wr) begin
          s_d.state = PFD_ARMED; // RL5
        end
      end
      PFD_ARMED: begin
        if (arm.arm_wr) begin
          s_d.state = PFD_ARMED;
        end else if (arm.disarm_wr) begin
          s_d.state = PFD_IDLE; // RL6 RL8
        end else if (arm.update) begin
          s_d.state = PFD_IDLE; // RL22
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '{state: PFD_IDLE};
    end else begin
      s_q <= s_d;
    end
  end
endmodule // pfd_arm_ctl

// *** rtl/pfd_arm_if.sv ***
// Arming handshake between a register group and its arming control
`timescale 1ns/1ns
interface pfd_arm_if;
  logic arm_wr;
  logic disarm_wr;
  logic update;
  logic load;
  logic armed;
  modport ctl  (input arm_wr, input disarm_wr, input update, output load, output armed);
  modport user (output arm_wr, output disarm_wr, output update, input load, input armed);
endinterface

// *** rtl/pfd_flip_dbuf.sv ***
// Double-buffered plane and cursor configuration with flip control
`timescale 1ns/1ns
module pfd_flip_dbuf (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  input  wire logic        I_VBLANK_START,
  input  wire logic        I_TLB_BOUNDARY,
  input  wire logic        I_CMD_FLIP,
  input  wire logic [31:0] I_CMD_FLIP_ADDR,
  input  wire logic        I_CMD_FLIP_ASYNC,
  output logic      [31:0] O_PLANE_CONTROL_LIVE,
  output logic      [31:0] O_PLANE_CFG_LIVE,
  output logic      [31:0] O_PLANE_SURFACE_ADDRESS_LIVE,
  output logic      [31:0] O_CUR_CTL_LIVE,
  output logic      [31:0] O_CURSOR_BASE_ADDRESS_LIVE,
  output logic             O_FLIP_DONE,
  output logic             O_FLIP_IRQ,
  output logic             O_WAKE
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] plane_control_p;
    logic [31:0] plane_cfg_p;
    logic [31:0] plane_surface_address_p;
    logic [31:0] plane_control_l;
    logic [31:0] plane_cfg_l;
    logic [31:0] plane_surface_address_l;
    logic [31:0] cur_ctl_p;
    logic [31:0] cursor_base_address_p;
    logic [31:0] cur_ctl_l;
    logic [31:0] cursor_base_address_l;
    logic [31:0] rrm;
    logic [1:0]  irq_cfg;
    logic        pipe_en;
    logic        async_pend;
    logic        flip_async;
    logic        flip_done;
    logic [31:0] rdata;
  } pfd_main_st_t;

  pfd_main_st_t s_q;
  pfd_main_st_t s_d;

  pfd_arm_if parm ();
  pfd_arm_if carm ();

  logic sticky;
  logic irq_q;
  logic wake_q;
  logic sts_clear;
  logic plane_off;

  pfd_arm_ctl u_plane_arm (
    .i_clk (I_MCLK),
    .i_rst (I_RST),
    .arm   (parm.ctl)
  );

  pfd_arm_ctl u_cur_arm (
    .i_clk (I_MCLK),
    .i_rst (I_RST),
    .arm   (carm.ctl)
  );

  pfd_flip_event u_event (
    .i_clk        (I_MCLK),
    .i_rst        (I_RST),
    .i_event      (s_d.flip_done),
    .i_clear      (sts_clear),
    .i_irq_mask   (s_q.irq_cfg[pfd_pkg::PFD_IRQ_MASK_BIT]),
    .i_irq_enable (s_q.irq_cfg[pfd_pkg::PFD_IRQ_EN_BIT]),
    .i_rrm_mask   (s_q.rrm[pfd_pkg::PFD_RRM_FLIP_BIT]),
    .o_sticky     (sticky),
    .o_irq        (irq_q),
    .o_wake       (wake_q)
  );

  // Plane counts as off when it or its pipe is disabled
  assign plane_off = !s_q.plane_control_l[pfd_pkg::PFD_CTL_ENABLE_BIT] || !s_q.pipe_en;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d            = s_q;
    s_d.flip_done  = 1'b0;
    s_d.rdata      = pfd_pkg::PFD_RST_ZERO;
    sts_clear      = 1'b0;
    parm.arm_wr    = 1'b0;
    parm.disarm_wr = 1'b0;
    parm.update    = I_VBLANK_START; // RL3
    carm.arm_wr    = 1'b0;
    carm.disarm_wr = 1'b0;
    carm.update    = I_VBLANK_START; // RL3

    // Group transfers at the update point
    if (parm.load) begin
      s_d.plane_control_l  = s_q.plane_control_p; // RL2 RL9
      s_d.plane_cfg_l  = s_q.plane_cfg_p; // RL2 RL12
      s_d.plane_surface_address_l = s_q.plane_surface_address_p;
      s_d.flip_done    = !s_q.flip_async;
    end
    if (carm.load) begin
      s_d.cur_ctl_l  = s_q.cur_ctl_p; // RL11
      s_d.cursor_base_address_l = s_q.cursor_base_address_p; // RL2
    end

    // Early surface update for async flips
    if (s_q.async_pend && (I_TLB_BOUNDARY || I_VBLANK_START)) begin
      s_d.plane_surface_address_l = s_q.plane_surface_address_p; // RL10 RL12
      s_d.async_pend   = 1'b0; // RL13
      s_d.flip_done    = 1'b1;
    end

    // Double-buffered register writes land in the pending stage, control and status words act at once
    if (I_WR) begin
      unique case (I_ADDR)
        pfd_pkg::PFD_OFF_PLANE_CONTROL: begin
          s_d.plane_control_p = I_WDATA; // RL1
          parm.disarm_wr  = 1'b1; // RL6
        end
        pfd_pkg::PFD_OFF_PLANE_CFG: begin
          s_d.plane_cfg_p = I_WDATA; // RL1
          parm.disarm_wr  = 1'b1; // RL6
        end
        pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS: begin
          s_d.plane_surface_address_p = I_WDATA; // RL1
          if (plane_off) begin
            s_d.plane_surface_address_l = I_WDATA; // RL16 RL17
            parm.arm_wr      = 1'b1; // RL15
            s_d.flip_done    = 1'b1; // RL16
          end else begin
            parm.arm_wr    = 1'b1; // RL15
            s_d.flip_async = s_q.plane_control_p[pfd_pkg::PFD_CTL_ASYNC_BIT]; // RL14
            s_d.async_pend = s_q.plane_control_p[pfd_pkg::PFD_CTL_ASYNC_BIT]; // RL14
          end
        end
        pfd_pkg::PFD_OFF_CUR_CTL: begin
          s_d.cur_ctl_p  = I_WDATA;
          carm.disarm_wr = 1'b1; // RL6
        end
        pfd_pkg::PFD_OFF_CURSOR_BASE_ADDRESS: begin
          s_d.cursor_base_address_p = I_WDATA;
          carm.arm_wr    = 1'b1; // RL15
        end
        pfd_pkg::PFD_OFF_STATUS: begin
          sts_clear = I_WDATA[pfd_pkg::PFD_STS_DONE_BIT];
        end
        pfd_pkg::PFD_OFF_RRM: begin
          s_d.rrm = I_WDATA;
        end
        pfd_pkg::PFD_OFF_IRQ_CFG: begin
          s_d.irq_cfg = I_WDATA[1:0];
        end
        pfd_pkg::PFD_OFF_PIPE_CTL: begin
          s_d.pipe_en = I_WDATA[pfd_pkg::PFD_PIPE_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    // Command stream flip arms by itself
    if (I_CMD_FLIP) begin
      s_d.plane_surface_address_p = I_CMD_FLIP_ADDR;
      s_d.plane_control_p[pfd_pkg::PFD_CTL_ASYNC_BIT] = I_CMD_FLIP_ASYNC;
      if (plane_off) begin
        s_d.plane_surface_address_l = I_CMD_FLIP_ADDR; // RL17
        parm.arm_wr      = 1'b1; // RL18
        s_d.flip_done    = 1'b1; // RL17
        s_d.async_pend   = 1'b0;
      end else begin
        parm.arm_wr    = 1'b1; // RL18
        parm.disarm_wr = 1'b0;
        s_d.flip_async = I_CMD_FLIP_ASYNC; // RL14
        s_d.async_pend = I_CMD_FLIP_ASYNC;
      end
    end

    // Reads return the pending stage of double-buffered words, plane live copies via read-only words
    if (I_RD) begin
      unique case (I_ADDR)
        pfd_pkg::PFD_OFF_PLANE_CONTROL:       s_d.rdata = s_q.plane_control_p; // RL1
        pfd_pkg::PFD_OFF_PLANE_CFG:       s_d.rdata = s_q.plane_cfg_p; // RL1
        pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS:      s_d.rdata = s_q.plane_surface_address_p; // RL1
        pfd_pkg::PFD_OFF_PLANE_CONTROL_LIVE:  s_d.rdata = s_q.plane_control_l; // RL4
        pfd_pkg::PFD_OFF_PLANE_CFG_LIVE:  s_d.rdata = s_q.plane_cfg_l; // RL4
        pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS_LIVE: s_d.rdata = s_q.plane_surface_address_l; // RL4
        pfd_pkg::PFD_OFF_CUR_CTL:         s_d.rdata = s_q.cur_ctl_p;
        pfd_pkg::PFD_OFF_CURSOR_BASE_ADDRESS:        s_d.rdata = s_q.cursor_base_address_p;
        pfd_pkg::PFD_OFF_STATUS: begin
          s_d.rdata[pfd_pkg::PFD_STS_DONE_BIT]  = sticky;
          s_d.rdata[pfd_pkg::PFD_STS_PARM_BIT]  = parm.armed;
          s_d.rdata[pfd_pkg::PFD_STS_CARM_BIT]  = carm.armed;
          s_d.rdata[pfd_pkg::PFD_STS_APEND_BIT] = s_q.async_pend;
        end
        pfd_pkg::PFD_OFF_RRM:             s_d.rdata = s_q.rrm;
        pfd_pkg::PFD_OFF_IRQ_CFG:         s_d.rdata = {{30{1'b0}}, s_q.irq_cfg};
        pfd_pkg::PFD_OFF_PIPE_CTL:        s_d.rdata = {{31{1'b0}}, s_q.pipe_en};
        default:                          s_d.rdata = pfd_pkg::PFD_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      s_q         <= '0;
      s_q.rrm     <= pfd_pkg::PFD_RST_RRM;
      s_q.irq_cfg <= pfd_pkg::PFD_RST_IRQ;
      s_q.pipe_en <= pfd_pkg::PFD_RST_PIPE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign O_RDATA           = s_q.rdata;
  assign O_PLANE_CONTROL_LIVE  = s_q.plane_control_l;
  assign O_PLANE_CFG_LIVE  = s_q.plane_cfg_l;
  assign O_PLANE_SURFACE_ADDRESS_LIVE = s_q.plane_surface_address_l;
  assign O_CUR_CTL_LIVE    = s_q.cur_ctl_l;
  assign O_CURSOR_BASE_ADDRESS_LIVE   = s_q.cursor_base_address_l;
  assign O_FLIP_DONE       = s_q.flip_done;
  assign O_FLIP_IRQ        = irq_q;
  assign O_WAKE            = wake_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  logic surf_wr;
  logic cfg_wr;
  assign surf_wr = I_WR && (I_ADDR == pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS);
  assign cfg_wr  = I_WR && (I_ADDR == pfd_pkg::PFD_OFF_PLANE_CFG);

  AST_PEND_READ: assert property ( // RL1
    I_RD && (I_ADDR == pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS) |=> O_RDATA == $past(s_q.plane_surface_address_p))
    else $error("pending surface read mismatch");

  AST_CFG_AT_VBLANK: assert property ( // RL2
    !$stable(O_PLANE_CFG_LIVE) |-> $past(I_VBLANK_START) && $past(parm.armed))
    else $error("live config changed away from update point");

  AST_LIVE_READ: assert property ( // RL4
    I_RD && (I_ADDR == pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS_LIVE) |=> O_RDATA == $past(O_PLANE_SURFACE_ADDRESS_LIVE))
    else $error("live surface read mismatch");

  AST_ARM_SET: assert property ( // RL5
    surf_wr && !plane_off |=> parm.armed)
    else $error("surface write did not arm");

  AST_DISARM: assert property ( // RL6
    cfg_wr && !I_CMD_FLIP |=> !parm.armed)
    else $error("config write did not disarm");

  AST_ASYNC_EARLY: assert property ( // RL10
    s_q.async_pend && I_TLB_BOUNDARY |=> O_FLIP_DONE && O_PLANE_SURFACE_ADDRESS_LIVE == $past(s_q.plane_surface_address_p))
    else $error("async surface not applied at TLB boundary");

  AST_CUR_SYNC: assert property ( // RL11
    !$stable(O_CURSOR_BASE_ADDRESS_LIVE) |-> $past(I_VBLANK_START))
    else $error("cursor base changed outside vertical blank");

  AST_CTL_SYNC: assert property ( // RL12
    !$stable(O_PLANE_CONTROL_LIVE) |-> $past(I_VBLANK_START))
    else $error("plane control changed outside vertical blank");

  AST_ASYNC_BOUND: assert property ( // RL13
    s_q.async_pend && I_VBLANK_START |=> !s_q.async_pend ##1 !s_q.async_pend || I_CMD_FLIP || I_WR)
    else $error("async flip outlived the frame");

  AST_OFF_DONE: assert property ( // RL16
    surf_wr && plane_off && !I_CMD_FLIP |=> O_FLIP_DONE && O_PLANE_SURFACE_ADDRESS_LIVE == $past(I_WDATA))
    else $error("disabled plane surface write not immediate");

  AST_CMD_ARM: assert property ( // RL18
    I_CMD_FLIP && !plane_off |=> parm.armed)
    else $error("command flip did not arm");

  AST_WAKE: assert property ( // RL20
    O_FLIP_DONE |-> O_WAKE == !$past(s_q.rrm[pfd_pkg::PFD_RRM_FLIP_BIT]))
    else $error("wake does not follow response mask");

  AST_DISARM_AFTER: assert property ( // RL22
    parm.load && !parm.arm_wr |=> !parm.armed)
    else $error("armed state kept after transfer");

  AST_SURF_AT_UPDATE: assert property ( // RL9
    !$stable(O_PLANE_SURFACE_ADDRESS_LIVE) |->
      $past(I_VBLANK_START) || $past(s_q.async_pend) || $past(plane_off))
    else $error("live surface changed away from an update point");

  AST_ASYNC_SEL: assert property ( // RL14
    surf_wr && !plane_off && !I_CMD_FLIP |=>
      s_q.async_pend == $past(s_q.plane_control_p[pfd_pkg::PFD_CTL_ASYNC_BIT]))
    else $error("flip type not taken from control bit");

  AST_CMD_ASYNC: assert property ( // RL14
    I_CMD_FLIP && !plane_off |=> s_q.async_pend == $past(I_CMD_FLIP_ASYNC))
    else $error("command flip type not honoured");

  AST_CUR_ARM: assert property ( // RL15
    I_WR && (I_ADDR == pfd_pkg::PFD_OFF_CURSOR_BASE_ADDRESS) |=> carm.armed)
    else $error("cursor base write did not arm");

  AST_CUR_DISARM: assert property ( // RL6
    I_WR && (I_ADDR == pfd_pkg::PFD_OFF_CUR_CTL) |=> !carm.armed)
    else $error("cursor control write did not disarm");

  AST_CMD_OFF: assert property ( // RL17
    I_CMD_FLIP && plane_off |=> O_FLIP_DONE && O_PLANE_SURFACE_ADDRESS_LIVE == $past(I_CMD_FLIP_ADDR))
    else $error("command flip to disabled plane not immediate");

  AST_IRQ_GATE: assert property ( // RL19
    O_FLIP_IRQ |-> $past(s_q.irq_cfg[pfd_pkg::PFD_IRQ_EN_BIT]) &&
      !$past(s_q.irq_cfg[pfd_pkg::PFD_IRQ_MASK_BIT]))
    else $error("interrupt raised while disabled or masked");

  AST_DONE_STICKY: assert property ( // RL19
    O_FLIP_DONE |-> sticky)
    else $error("flip done not recorded in status");

  AST_CUR_CTL_SYNC: assert property ( // RL11
    !$stable(O_CUR_CTL_LIVE) |-> $past(I_VBLANK_START) && $past(carm.armed))
    else $error("cursor control changed outside update point");

  AST_LOAD_ALL: assert property ( // RL2
    parm.load |=> O_PLANE_CONTROL_LIVE == $past(s_q.plane_control_p) &&
      O_PLANE_CFG_LIVE == $past(s_q.plane_cfg_p))
    else $error("pending group not copied at update point");

  AST_PEND_WRITE: assert property ( // RL1
    cfg_wr |=> s_q.plane_cfg_p == $past(I_WDATA))
    else $error("config write missed the pending stage");

  COV_SYNC_FLIP: cover property (surf_wr && !plane_off ##[1:50] parm.load);
  COV_ASYNC_FLIP: cover property (s_q.async_pend && I_TLB_BOUNDARY && !I_VBLANK_START);
  COV_OFF_FLIP: cover property (surf_wr && plane_off);
  COV_CUR_FLIP: cover property (carm.load);

endmodule // pfd_flip_dbuf

// *** rtl/pfd_flip_event.sv ***
// Flip done sticky status, interrupt and engine wake
`timescale 1ns/1ns
module pfd_flip_event (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_event,
  input  wire logic i_clear,
  input  wire logic i_irq_mask,
  input  wire logic i_irq_enable,
  input  wire logic i_rrm_mask,
  output logic      o_sticky,
  output logic      o_irq,
  output logic      o_wake
);
  typedef struct packed {
    logic sticky;
    logic irq;
    logic wake;
  } pfd_evt_st_t;

  pfd_evt_st_t s_q;
  pfd_evt_st_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.sticky = i_event || (s_q.sticky && !i_clear);
    s_d.irq    = s_d.sticky && i_irq_enable && !i_irq_mask; // RL19
    s_d.wake   = i_event && !i_rrm_mask; // RL20
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sticky = s_q.sticky;
  assign o_irq    = s_q.irq;
  assign o_wake   = s_q.wake;
endmodule // pfd_flip_event

// *** rtl/pfd_pkg.sv ***
// Constants and shared types for the plane flip double buffer
// How it works
// [RL1] Software reads and writes reach the pending stage
// [RL2] Update point copies pending into live stage
// [RL3] Normal update point is vertical blank start
// [RL4] Plane live values readable through read-only registers
// [RL5] Arming register write arms the whole group
// [RL6] Other group writes disarm and block update
// [RL7] Host writes arming register last
// [RL8] Touching armed group disarms until rearmed
// [RL9] Sync flip applies everything at vertical blank
// [RL10] Async surface applies at TLB or vblank
// [RL11] Cursors never flip asynchronously
// [RL12] Async flip moves only the surface address
// [RL13] Async flip completes within one frame
// [RL14] Control bit selects sync or async flip
// [RL15] Surface or cursor base write arms
// [RL16] Disabled plane surface write completes at once
// [RL17] Flip to disabled plane or pipe completes immediately
// [RL18] Command flip arms the plane itself
// [RL19] Plane flip done raises maskable enableable interrupt
// [RL20] Unmasked flip done wakes graphics engine
// [RL21] Host keeps refresh push out of plane pair
// [RL22] Transfer clears the armed state
package pfd_pkg;

  typedef logic [7:0]  pfd_addr_t;
  typedef logic [31:0] pfd_word_t;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam pfd_addr_t PFD_OFF_PLANE_CONTROL      = 8'h00;
  localparam pfd_addr_t PFD_OFF_PLANE_CFG      = 8'h04;
  localparam pfd_addr_t PFD_OFF_PLANE_SURFACE_ADDRESS     = 8'h08;
  localparam pfd_addr_t PFD_OFF_PLANE_CONTROL_LIVE = 8'h0C;
  localparam pfd_addr_t PFD_OFF_PLANE_CFG_LIVE = 8'h10;
  localparam pfd_addr_t PFD_OFF_PLANE_SURFACE_ADDRESS_LIVE = 8'h14;
  localparam pfd_addr_t PFD_OFF_CUR_CTL        = 8'h18;
  localparam pfd_addr_t PFD_OFF_CURSOR_BASE_ADDRESS       = 8'h1C;
  localparam pfd_addr_t PFD_OFF_STATUS         = 8'h20;
  localparam pfd_addr_t PFD_OFF_RRM            = 8'h24;
  localparam pfd_addr_t PFD_OFF_IRQ_CFG        = 8'h28;
  localparam pfd_addr_t PFD_OFF_PIPE_CTL       = 8'h2C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned PFD_CTL_ENABLE_BIT  = 0;
  localparam int unsigned PFD_CTL_ASYNC_BIT   = 1;
  localparam int unsigned PFD_STS_DONE_BIT    = 0;
  localparam int unsigned PFD_STS_PARM_BIT    = 1;
  localparam int unsigned PFD_STS_CARM_BIT    = 2;
  localparam int unsigned PFD_STS_APEND_BIT   = 3;
  localparam int unsigned PFD_RRM_FLIP_BIT    = 0;
  localparam int unsigned PFD_IRQ_MASK_BIT    = 0;
  localparam int unsigned PFD_IRQ_EN_BIT      = 1;
  localparam int unsigned PFD_PIPE_EN_BIT     = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam pfd_word_t PFD_RST_ZERO    = 32'h0000_0000;
  localparam pfd_word_t PFD_RST_RRM     = 32'h0000_0001;
  localparam logic [1:0] PFD_RST_IRQ    = 2'h1;
  localparam logic       PFD_RST_PIPE   = 1'h0;

endpackage

// *** test/tb_top.sv ***
// Self-checking bench for the plane flip double buffer
`timescale 1ns/1ns
module tb_top;
  logic        I_MCLK;
  logic        I_RST;
  logic [7:0]  I_ADDR;
  logic [31:0] I_WDATA;
  logic        I_WR;
  logic        I_RD;
  logic [31:0] O_RDATA;
  logic        I_VBLANK_START;
  logic        I_TLB_BOUNDARY;
  logic        I_CMD_FLIP;
  logic [31:0] I_CMD_FLIP_ADDR;
  logic        I_CMD_FLIP_ASYNC;
  logic [31:0] O_PLANE_CONTROL_LIVE;
  logic [31:0] O_PLANE_CFG_LIVE;
  logic [31:0] O_PLANE_SURFACE_ADDRESS_LIVE;
  logic [31:0] O_CUR_CTL_LIVE;
  logic [31:0] O_CURSOR_BASE_ADDRESS_LIVE;
  logic        O_FLIP_DONE;
  logic        O_FLIP_IRQ;
  logic        O_WAKE;
  int unsigned n_fail;
  int unsigned checks;
  int unsigned n_done;
  int unsigned n_wake;
  int unsigned d_mark;
  int unsigned w_mark;
  int unsigned cycles;

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch at %0t got %h expected %h", $time, (got), (exp)); end end

  pfd_flip_dbuf dut_u (
    .I_MCLK           (I_MCLK),
    .I_RST            (I_RST),
    .I_ADDR           (I_ADDR),
    .I_WDATA          (I_WDATA),
    .I_WR             (I_WR),
    .I_RD             (I_RD),
    .O_RDATA          (O_RDATA),
    .I_VBLANK_START   (I_VBLANK_START),
    .I_TLB_BOUNDARY   (I_TLB_BOUNDARY),
    .I_CMD_FLIP       (I_CMD_FLIP),
    .I_CMD_FLIP_ADDR  (I_CMD_FLIP_ADDR),
    .I_CMD_FLIP_ASYNC (I_CMD_FLIP_ASYNC),
    .O_PLANE_CONTROL_LIVE (O_PLANE_CONTROL_LIVE),
    .O_PLANE_CFG_LIVE (O_PLANE_CFG_LIVE),
    .O_PLANE_SURFACE_ADDRESS_LIVE(O_PLANE_SURFACE_ADDRESS_LIVE),
    .O_CUR_CTL_LIVE   (O_CUR_CTL_LIVE),
    .O_CURSOR_BASE_ADDRESS_LIVE  (O_CURSOR_BASE_ADDRESS_LIVE),
    .O_FLIP_DONE      (O_FLIP_DONE),
    .O_FLIP_IRQ       (O_FLIP_IRQ),
    .O_WAKE           (O_WAKE)
  );

  // ****************************************
  // Clock, pulse counters and hang guard
  // ****************************************
  initial begin
    I_MCLK = 1'b0;
    forever #20 I_MCLK = ~I_MCLK;
  end

  always @(posedge I_MCLK) begin
    cycles++;
    if (O_FLIP_DONE === 1'b1) n_done++;
    if (O_WAKE === 1'b1) n_wake++;
    if (cycles == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Bus and event tasks
  // ****************************************
  task automatic wr(input pfd_pkg::pfd_addr_t a, input pfd_pkg::pfd_word_t d);
    @(posedge I_MCLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
    #1;
  endtask

  task automatic rchk(input pfd_pkg::pfd_addr_t a, input pfd_pkg::pfd_word_t exp);
    @(posedge I_MCLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1;
    `CHK(O_RDATA, exp)
  endtask

  // Pulses vblank, TLB boundary or a command flip for one cycle
  task automatic ev(input logic vb, input logic tlb, input logic cf,
                    input pfd_pkg::pfd_word_t ca);
    @(posedge I_MCLK);
    I_VBLANK_START <= vb;
    I_TLB_BOUNDARY <= tlb;
    I_CMD_FLIP <= cf;
    I_CMD_FLIP_ADDR <= ca;
    @(posedge I_MCLK);
    I_VBLANK_START <= 1'b0;
    I_TLB_BOUNDARY <= 1'b0;
    I_CMD_FLIP <= 1'b0;
    #1;
  endtask

  task automatic mark();
    d_mark = n_done;
    w_mark = n_wake;
  endtask

  // Done and wake pulses seen since the last mark
  task automatic cnt(input int unsigned dd, input int unsigned wd);
    @(posedge I_MCLK);
    #1;
    `CHK(n_done - d_mark, dd)
    `CHK(n_wake - w_mark, wd)
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    n_fail = 0;
    checks = 0;
    n_done = 0;
    n_wake = 0;
    cycles = 0;
    I_RST = 1'b1;
    I_ADDR = 8'h00;
    I_WDATA = 32'h0000_0000;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_VBLANK_START = 1'b0;
    I_TLB_BOUNDARY = 1'b0;
    I_CMD_FLIP = 1'b0;
    I_CMD_FLIP_ADDR = 32'h0000_0000;
    I_CMD_FLIP_ASYNC = 1'b0;
    repeat (3) @(posedge I_MCLK);
    I_RST <= 1'b0;
    rchk(pfd_pkg::PFD_OFF_RRM, 32'h0000_0001);
    rchk(pfd_pkg::PFD_OFF_IRQ_CFG, 32'h0000_0001);
    rchk(pfd_pkg::PFD_OFF_STATUS, 32'h0000_0000);
    rchk(8'hF0, 32'h0000_0000);
    // Disabled plane: surface bypasses, control waits for vblank
    wr(pfd_pkg::PFD_OFF_PIPE_CTL, 32'h0000_0001);
    wr(pfd_pkg::PFD_OFF_PLANE_CONTROL, 32'h0000_0001);
    mark();
    wr(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS, 32'h1000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h1000_0000)
    `CHK(O_PLANE_CONTROL_LIVE, 32'h0000_0000)
    cnt(1, 0);
    ev(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_CONTROL_LIVE, 32'h0000_0001)
    wr(pfd_pkg::PFD_OFF_STATUS, 32'h0000_0001);
    // Sync flip
    wr(pfd_pkg::PFD_OFF_PLANE_CFG, 32'h0000_00A5);
    wr(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS, 32'h2000_0000);
    mark();
    rchk(pfd_pkg::PFD_OFF_STATUS, 32'h0000_0002);
    rchk(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS, 32'h2000_0000);
    ev(1'b0, 1'b1, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h1000_0000)
    ev(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h2000_0000)
    `CHK(O_PLANE_CFG_LIVE, 32'h0000_00A5)
    cnt(1, 0);
    rchk(pfd_pkg::PFD_OFF_STATUS, 32'h0000_0001);
    wr(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS_LIVE, 32'hDEAD_0000);
    rchk(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS_LIVE, 32'h2000_0000);
    rchk(pfd_pkg::PFD_OFF_PLANE_CFG_LIVE, 32'h0000_00A5);
    // Disarm by a later control-group write, then rearm
    wr(pfd_pkg::PFD_OFF_STATUS, 32'h0000_0001);
    mark();
    wr(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS, 32'h3000_0000);
    wr(pfd_pkg::PFD_OFF_PLANE_CFG, 32'h0000_005A);
    rchk(pfd_pkg::PFD_OFF_STATUS, 32'h0000_0000);
    ev(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h2000_0000)
    cnt(0, 0);
    wr(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS, 32'h3000_0000);
    ev(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_CFG_LIVE, 32'h0000_005A)
    cnt(1, 0);
    mark();
    ev(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    cnt(0, 0);
    // Async flip: surface at TLB boundary, rest at vblank
    wr(pfd_pkg::PFD_OFF_PLANE_CONTROL, 32'h0000_0003);
    wr(pfd_pkg::PFD_OFF_PLANE_CFG, 32'h0000_0077);
    wr(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS, 32'h4000_0000);
    mark();
    ev(1'b0, 1'b1, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h4000_0000)
    `CHK(O_PLANE_CFG_LIVE, 32'h0000_005A)
    cnt(1, 0);
    ev(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_CONTROL_LIVE, 32'h0000_0003)
    `CHK(O_PLANE_CFG_LIVE, 32'h0000_0077)
    cnt(1, 0);
    wr(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS, 32'h4100_0000);
    ev(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h4100_0000)
    // Cursor: never async, no flip done
    wr(pfd_pkg::PFD_OFF_CUR_CTL, 32'h0000_0021);
    wr(pfd_pkg::PFD_OFF_CURSOR_BASE_ADDRESS, 32'h5000_0000);
    mark();
    ev(1'b0, 1'b1, 1'b0, 32'h0000_0000);
    `CHK(O_CURSOR_BASE_ADDRESS_LIVE, 32'h0000_0000)
    ev(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_CURSOR_BASE_ADDRESS_LIVE, 32'h5000_0000)
    `CHK(O_CUR_CTL_LIVE, 32'h0000_0021)
    cnt(0, 0);
    // Command flip with wake and interrupt unmasked
    wr(pfd_pkg::PFD_OFF_STATUS, 32'h0000_0001);
    wr(pfd_pkg::PFD_OFF_RRM, 32'h0000_0000);
    wr(pfd_pkg::PFD_OFF_IRQ_CFG, 32'h0000_0002);
    mark();
    ev(1'b0, 1'b0, 1'b1, 32'h6000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h4100_0000)
    ev(1'b1, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h6000_0000)
    cnt(1, 1);
    `CHK(O_FLIP_IRQ, 1'b1)
    rchk(pfd_pkg::PFD_OFF_STATUS, 32'h0000_0001);
    wr(pfd_pkg::PFD_OFF_IRQ_CFG, 32'h0000_0003);
    ev(1'b0, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_FLIP_IRQ, 1'b0)
    wr(pfd_pkg::PFD_OFF_IRQ_CFG, 32'h0000_0002);
    wr(pfd_pkg::PFD_OFF_STATUS, 32'h0000_0001);
    ev(1'b0, 1'b0, 1'b0, 32'h0000_0000);
    `CHK(O_FLIP_IRQ, 1'b0)
    // Async command flip lands at the TLB boundary
    @(posedge I_MCLK);
    I_CMD_FLIP_ASYNC <= 1'b1;
    mark();
    ev(1'b0, 1'b0, 1'b1, 32'h6800_0000);
    ev(1'b0, 1'b1, 1'b0, 32'h0000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h6800_0000)
    cnt(1, 1);
    @(posedge I_MCLK);
    I_CMD_FLIP_ASYNC <= 1'b0;
    // Disabled pipe completes at once, wake masked again
    wr(pfd_pkg::PFD_OFF_RRM, 32'h0000_0001);
    wr(pfd_pkg::PFD_OFF_PIPE_CTL, 32'h0000_0000);
    mark();
    wr(pfd_pkg::PFD_OFF_PLANE_SURFACE_ADDRESS, 32'h7000_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h7000_0000)
    ev(1'b0, 1'b0, 1'b1, 32'h7100_0000);
    `CHK(O_PLANE_SURFACE_ADDRESS_LIVE, 32'h7100_0000)
    cnt(2, 0);
    tally_and_finish();
  end
endmodule  // tb_top
